// [shared/lcdini_pkg.sv]
/*
  Constants shared by the character LCD controller host interface and its
  frame timing generator: clock figures, instruction encodings, field positions
  and reset values.
  Assumes a single 125 MHz system clock that stands in for the internal RC
  oscillator of the controller.
*/
package lcdini_pkg;

  // ==========================================================================
  // Clock and oscillator figures
  // ==========================================================================
  localparam int CLOCK_HZ              = 125_000_000;
  localparam int CLOCK_PERIOD_NS       = 8;
  localparam int OSCILLATOR_FREQ_HZ    = 270_000;
  localparam int OSCILLATOR_FREQ_MHZ   = 270_000_000;  // Milli-hertz, for frame math.
  // System clocks per oscillator period, rounded to nearest.
  localparam int RC_TICK_CYCLES        = (CLOCK_HZ + OSCILLATOR_FREQ_HZ / 2) / OSCILLATOR_FREQ_HZ;

  // Frame rates at the reference oscillator, in milli-hertz, one per duty.
  localparam int FRAME_MHZ_DUTY8       = 84_400;
  localparam int FRAME_MHZ_DUTY9       = 75_000;
  localparam int FRAME_MHZ_DUTY16      = 84_400;
  localparam int FRAME_MHZ_DUTY17      = 79_400;

  // Oscillator periods in one frame for a given frame rate.
  function automatic int rcTicksPerFrame(input int frameMhz);
    return (OSCILLATOR_FREQ_MHZ + frameMhz / 2) / frameMhz;
  endfunction : rcTicksPerFrame

  // Number of commons without the arbitrator line.
  localparam int COM_ONE_LINE          = 8;
  localparam int COM_TWO_LINE          = 16;
  // Oscillator periods per common line; the arbitrator line adds one more.
  localparam int LINE_TICKS_ONE        =
    (rcTicksPerFrame(FRAME_MHZ_DUTY8) + COM_ONE_LINE / 2) / COM_ONE_LINE;
  localparam int LINE_TICKS_TWO        =
    (rcTicksPerFrame(FRAME_MHZ_DUTY16) + COM_TWO_LINE / 2) / COM_TWO_LINE;

  // Instruction execution time and its busy count, rounded up.
  localparam int EXEC_TIME_NS          = 37_000;
  localparam int EXEC_CYCLES           = (EXEC_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ==========================================================================
  // Register select codes and instruction fields
  // ==========================================================================
  localparam logic [1:0] SEL_EXPANSION = 2'h0;  // Select high 0, select low 0.
  localparam logic [1:0] SEL_COMMAND   = 2'h2;  // Select high 1, select low 0.
  localparam logic [2:0] FSET_TAG      = 3'h1;  // Upper three bits of a function setting.
  localparam logic [3:0] WIDTH8_NIBBLE = 4'h3;
  localparam int         FSET_WIDTH_BIT = 4;
  localparam int         FSET_LINES_BIT = 3;
  localparam int         FSET_FONT_BIT  = 2;
  localparam logic [6:0] ARB_LINE_CODE = 7'h01;  // Upper seven bits of the line setting.
  localparam int         ARB_SELECT_BIT = 0;
  localparam int         STATUS_BUSY_BIT = 7;
  localparam logic [3:0] SERIAL_RW_COUNT = 4'h2;  // Bit index of the direction bit.
  localparam logic [3:0] SERIAL_LAST_BIT = 4'hA;  // Eleven bits per serial frame.

  // Reset values, and the early count that ends the width sequence.
  localparam logic       RST_WIDE      = 1'b1;
  localparam logic       RST_LINES     = 1'b0;
  localparam logic       RST_FONT      = 1'b0;
  localparam logic [1:0] RST_EARLY     = 2'h0;
  localparam logic [1:0] EARLY_DONE    = 2'h3;

endpackage : lcdini_pkg

// [src/lcdini_frame_gen.sv]
/*
  Common scan timing generator: steps through the common lines at a rate
  derived from the oscillator figure and pulses once per frame.
  Assumes the mode inputs come from flip-flops on the same clock.
*/
`timescale 1ns/1ps
module lcdini_frame_gen (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Scan mode
  input  wire logic       twoLine,
  input  wire logic       arbEnable,
  // Scan position
  output logic      [4:0] comIndex,
  output logic            framePulse
);

  logic [9:0] tickCount_reg;
  logic [8:0] lineTick_reg;
  logic [1:0] mode_reg;
  logic [8:0] lineLen;
  logic [4:0] comLast;
  logic       rcTick;

  // ==========================================================================
  // Scan counters
  // ==========================================================================
  // Line length and common count follow the duty; the arbitrator adds a common.
  assign lineLen = twoLine ? 9'(lcdini_pkg::LINE_TICKS_TWO) : 9'(lcdini_pkg::LINE_TICKS_ONE);
  assign comLast = 5'((twoLine ? lcdini_pkg::COM_TWO_LINE : lcdini_pkg::COM_ONE_LINE) - 1)
                   + {4'h0, arbEnable};
  assign rcTick  = (tickCount_reg == 10'(lcdini_pkg::RC_TICK_CYCLES - 1));

  // A mode change restarts the frame so that no frame mixes two durations.
  always_ff @(posedge clock) begin
    if (!resetn || mode_reg != {twoLine, arbEnable}) begin
      tickCount_reg <= 10'h000;
      lineTick_reg  <= 9'h000;
      comIndex      <= 5'h00;
      framePulse    <= 1'b0;
      mode_reg      <= {twoLine, arbEnable};
    end else begin
      framePulse    <= 1'b0;
      tickCount_reg <= rcTick ? 10'h000 : tickCount_reg + 10'h001;
      if (rcTick) begin
        lineTick_reg <= (lineTick_reg == lineLen - 9'h001) ? 9'h000 : lineTick_reg + 9'h001;
        if (lineTick_reg == lineLen - 9'h001) begin
          comIndex <= (comIndex == comLast) ? 5'h00 : comIndex + 5'h01;
          framePulse <= (comIndex == comLast);
        end
      end
    end
  end

  // ==========================================================================
  // Checks on the frame period
  // ==========================================================================
  localparam int T8  = lcdini_pkg::rcTicksPerFrame(lcdini_pkg::FRAME_MHZ_DUTY8)
                       * lcdini_pkg::RC_TICK_CYCLES;
  localparam int T16 = lcdini_pkg::rcTicksPerFrame(lcdini_pkg::FRAME_MHZ_DUTY16)
                       * lcdini_pkg::RC_TICK_CYCLES;
  localparam int T9  = lcdini_pkg::rcTicksPerFrame(lcdini_pkg::FRAME_MHZ_DUTY9)
                       * lcdini_pkg::RC_TICK_CYCLES;
  localparam int T17 = lcdini_pkg::rcTicksPerFrame(lcdini_pkg::FRAME_MHZ_DUTY17)
                       * lcdini_pkg::RC_TICK_CYCLES;
  localparam int TOL = 2 * lcdini_pkg::RC_TICK_CYCLES;

  logic [31:0] gapCount;
  logic        gapValid;
  int          expectGap;

  // Cycles since the last frame pulse; only a whole frame in one mode counts.
  always_ff @(posedge clock) begin
    if (!resetn || mode_reg != {twoLine, arbEnable}) begin
      gapCount <= 32'h00000000;
      gapValid <= 1'b0;
    end else begin
      gapCount <= framePulse ? 32'h00000001 : gapCount + 32'h00000001;
      gapValid <= gapValid | framePulse;
    end
  end

  always_comb begin
    expectGap = twoLine ? (arbEnable ? T17 : T16) : (arbEnable ? T9 : T8);
  end

  property p_frame_plain;
    @(posedge clock) disable iff (!resetn)
      framePulse && gapValid && !arbEnable |->
        int'(gapCount) >= expectGap - TOL && int'(gapCount) <= expectGap + TOL;
  endproperty
  a_frame_plain: assert property (p_frame_plain)
    else $error("Frame period off the 84.4 Hz figure.");

  property p_frame_arb;
    @(posedge clock) disable iff (!resetn)
      framePulse && gapValid && arbEnable |->
        int'(gapCount) >= expectGap - TOL && int'(gapCount) <= expectGap + TOL;
  endproperty
  a_frame_arb: assert property (p_frame_arb)
    else $error("Frame period off the arbitrator duty figure.");

endmodule : lcdini_frame_gen

// [src/lcdini_host_if.sv]
/*
  Host side of a character LCD controller: parallel 8-bit, parallel 4-bit and
  serial instruction transfer, the power-up width sequence, the lock of line
  count and font, busy flag reads, and the common scan timing.
  Assumes asynchronous host pins, a core that supplies the address counter and
  consumes the decoded instructions, and a testbench that resolves the pins.
*/
`timescale 1ns/1ps
module lcdini_host_if #(
  parameter int BUSY_CYCLES = lcdini_pkg::EXEC_CYCLES
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Host pins
  input  wire logic       serialModePin,
  input  wire logic       enablePin,
  input  wire logic       readWritePin,
  input  wire logic       registerSelectHigh,
  input  wire logic       registerSelectLow,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic      [7:0] dataOe,
  // Core side
  input  wire logic [6:0] addressCounter,
  input  wire logic       arbitratorLineEnable,
  output logic            instrValid,
  output logic      [1:0] instrSelect,
  output logic      [7:0] instrByte,
  // Status
  output logic            busyIndicator,
  output logic            interfaceWide,
  output logic            settingsLocked,
  output logic            lineCount,
  output logic            fontSize,
  output logic            arbitratorSelect,
  output logic      [4:0] comIndex,
  output logic            framePulse
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [12:0] pinS1, pinS2, pinS3, pinStable;
  logic        ePrev;

  // Three stages; a bit changes only once stages two and three agree.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pinS1     <= 13'h0000;
      pinS2     <= 13'h0000;
      pinS3     <= 13'h0000;
      pinStable <= 13'h0000;
      ePrev     <= 1'b0;
    end else begin
      pinS1     <= {serialModePin, enablePin, readWritePin, registerSelectHigh,
                    registerSelectLow, dataIn};
      pinS2     <= pinS1;
      pinS3     <= pinS2;
      pinStable <= (pinS2 & pinS3) | (pinStable & (pinS2 ^ pinS3));
      ePrev     <= pinStable[11];
    end
  end

  logic       serialMode, eLevel, rwLevel, csN, eRise, eFall, parWrite, parRead;
  logic [1:0] sel;
  logic [7:0] dIn;
  assign serialMode = pinStable[12];
  assign eLevel     = pinStable[11];
  assign rwLevel    = pinStable[10];
  assign sel        = pinStable[9:8];
  assign csN        = pinStable[8];   // Select low doubles as chip select in serial.
  assign dIn        = pinStable[7:0];
  assign eRise      = eLevel & ~ePrev;
  assign eFall      = ~eLevel & ePrev;
  assign parWrite   = ~serialMode & eFall & ~rwLevel;
  assign parRead    = ~serialMode & eRise & rwLevel;

  // ==========================================================================
  // Serial framing: select high, select low, direction, then eight data bits
  // ==========================================================================
  logic [3:0] serBit_reg;
  logic [2:0] serHeader_reg;
  logic [7:0] serData_reg;
  logic       serReading_reg;
  logic       serRise, serDone;
  assign serRise = serialMode & eRise & ~csN;
  assign serDone = serRise & (serBit_reg == lcdini_pkg::SERIAL_LAST_BIT) & ~serReading_reg;

  // Chip select high abandons a partial frame.
  always_ff @(posedge clock) begin
    if (!resetn || csN || !serialMode) begin
      serBit_reg     <= 4'h0;
      serHeader_reg  <= 3'h0;
      serData_reg    <= 8'h00;
      serReading_reg <= 1'b0;
    end else if (serRise) begin
      serBit_reg <= (serBit_reg == lcdini_pkg::SERIAL_LAST_BIT) ? 4'h0 : serBit_reg + 4'h1;
      if (serBit_reg <= lcdini_pkg::SERIAL_RW_COUNT) begin
        serHeader_reg <= {serHeader_reg[1:0], rwLevel};
      end else begin
        serData_reg <= {serData_reg[6:0], rwLevel};
      end
      if (serBit_reg == lcdini_pkg::SERIAL_RW_COUNT) begin
        serReading_reg <= rwLevel;
      end
    end
  end

  // ==========================================================================
  // Write acceptance and nibble assembly
  // ==========================================================================
  logic       wide_reg, locked_reg, nibblePhase_reg;
  logic [3:0] nibbleHold_reg;
  logic [1:0] early_reg;
  logic       accept, fromEarly, earlyNibble, isFset, lockNow;
  logic [1:0] acceptSel;
  logic [7:0] acceptByte;

  // An early width nibble counts alone, so a host unsure of the width recovers.
  assign earlyNibble = parWrite & ~wide_reg & ~locked_reg & ~nibblePhase_reg
                       & (sel == lcdini_pkg::SEL_COMMAND)
                       & (dIn[7:4] == lcdini_pkg::WIDTH8_NIBBLE);

  always_comb begin
    accept     = 1'b0;
    fromEarly  = 1'b0;
    acceptSel  = sel;
    acceptByte = dIn;
    if (serialMode) begin
      accept     = serDone;
      acceptSel  = serHeader_reg[2:1];
      acceptByte = {serData_reg[6:0], rwLevel};
    end else if (parWrite && wide_reg) begin
      accept = 1'b1;
    end else if (earlyNibble) begin
      accept     = 1'b1;
      fromEarly  = 1'b1;
      acceptByte = {dIn[7:4], 4'h0};
    end else if (parWrite && nibblePhase_reg) begin
      accept     = 1'b1;
      acceptByte = {nibbleHold_reg, dIn[7:4]};
    end
    accept = accept & ~busyIndicator;  // Busy drops everything but status reads.
  end

  assign isFset  = (acceptSel == lcdini_pkg::SEL_COMMAND)
                   & (acceptByte[7:5] == lcdini_pkg::FSET_TAG);
  // In 8-bit mode a width-4 byte is the switch, not the final setting.
  assign lockNow = accept & isFset & ~locked_reg & ~fromEarly
                   & (serialMode | ((early_reg == lcdini_pkg::EARLY_DONE)
                      & ~(wide_reg & ~acceptByte[lcdini_pkg::FSET_WIDTH_BIT])));

  // Interface width follows every function setting in the parallel modes.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wide_reg <= lcdini_pkg::RST_WIDE;
    end else if (accept && isFset && !serialMode) begin
      wide_reg <= acceptByte[lcdini_pkg::FSET_WIDTH_BIT];
    end
  end

  // Nibble phase: the first half is held, the second completes the byte.
  always_ff @(posedge clock) begin
    if (!resetn || serialMode || wide_reg) begin
      nibblePhase_reg <= 1'b0;
      nibbleHold_reg  <= 4'h0;
    end else if (accept && isFset && acceptByte[lcdini_pkg::FSET_WIDTH_BIT]) begin
      nibblePhase_reg <= 1'b0;
    end else if (parWrite && !busyIndicator && !earlyNibble) begin
      nibblePhase_reg <= ~nibblePhase_reg;
      nibbleHold_reg  <= dIn[7:4];
    end
  end

  // Count early width commands, then freeze lines and font for good.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      early_reg  <= lcdini_pkg::RST_EARLY;
      locked_reg <= 1'b0;
      lineCount  <= lcdini_pkg::RST_LINES;
      fontSize   <= lcdini_pkg::RST_FONT;
    end else begin
      if (accept && isFset && !locked_reg && early_reg != lcdini_pkg::EARLY_DONE
          && acceptByte[7:4] == lcdini_pkg::WIDTH8_NIBBLE) begin
        early_reg <= early_reg + 2'h1;
      end
      if (lockNow) begin
        locked_reg <= 1'b1;
        lineCount  <= acceptByte[lcdini_pkg::FSET_LINES_BIT];
        fontSize   <= acceptByte[lcdini_pkg::FSET_FONT_BIT];
      end
    end
  end
  assign settingsLocked = locked_reg;
  assign interfaceWide  = wide_reg;

  // Busy timer, arbitrator line choice and the instruction hand-off to the core.
  logic [19:0] busyCount_reg;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      busyCount_reg    <= 20'h00000;
      arbitratorSelect <= 1'b0;
      instrValid       <= 1'b0;
      instrSelect      <= 2'h0;
      instrByte        <= 8'h00;
    end else begin
      instrValid <= accept;
      if (accept) begin
        busyCount_reg <= 20'(BUSY_CYCLES);
        instrSelect   <= acceptSel;
        instrByte     <= acceptByte;
      end else if (busyCount_reg != 20'h00000) begin
        busyCount_reg <= busyCount_reg - 20'h00001;
      end
      if (accept && acceptSel == lcdini_pkg::SEL_EXPANSION
          && acceptByte[7:1] == lcdini_pkg::ARB_LINE_CODE) begin
        arbitratorSelect <= acceptByte[lcdini_pkg::ARB_SELECT_BIT];
      end
    end
  end
  assign busyIndicator = (busyCount_reg != 20'h00000);

  // ==========================================================================
  // Status reads
  // ==========================================================================
  logic [7:0] status, serShift_reg;
  logic       readPhase_reg;
  assign status = {busyIndicator, addressCounter};

  // Parallel reads load on the rising strobe; serial reads shift out per clock.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      dataOut       <= 8'h00;
      readPhase_reg <= 1'b0;
      serShift_reg  <= 8'h00;
    end else if (parRead) begin
      if (sel != lcdini_pkg::SEL_COMMAND) begin
        dataOut <= 8'h00;
      end else if (wide_reg) begin
        dataOut <= status;
      end else begin
        dataOut       <= {readPhase_reg ? status[3:0] : status[7:4], 4'h0};
        readPhase_reg <= ~readPhase_reg;
      end
    end else if (serRise) begin
      if (serBit_reg == lcdini_pkg::SERIAL_RW_COUNT) begin
        serShift_reg <= {status[6:0], 1'b0};
        dataOut      <= {7'h00, status[lcdini_pkg::STATUS_BUSY_BIT]};
      end else begin
        serShift_reg <= {serShift_reg[6:0], 1'b0};
        dataOut      <= {7'h00, serShift_reg[7]};
      end
    end
  end

  // Drive the data lines while the host strobes a read; in serial, bit 0 only, from the direction bit until chip select rises.
  assign dataOe = serialMode ? {7'h00, serReading_reg & ~csN}
                             : {8{eLevel & rwLevel}};

  lcdini_frame_gen u_frame (
    .clock      (clock),
    .resetn     (resetn),
    .twoLine    (lineCount),
    .arbEnable  (arbitratorLineEnable),
    .comIndex   (comIndex),
    .framePulse (framePulse)
  );

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_lock_hold;
    @(posedge clock) disable iff (!resetn)
      locked_reg |=> locked_reg && $stable(lineCount) && $stable(fontSize);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("Line count or font changed after the lock.");

  property p_lock_take;
    @(posedge clock) disable iff (!resetn)
      lockNow |=> lineCount == $past(acceptByte[3]) && fontSize == $past(acceptByte[2]);
  endproperty
  a_lock_take: assert property (p_lock_take)
    else $error("Final setting not captured at the lock.");

  property p_nibble_pair;
    @(posedge clock) disable iff (!resetn)
      parWrite && !wide_reg && !busyIndicator && !earlyNibble && nibblePhase_reg |=>
        instrValid && instrByte == {$past(nibbleHold_reg), $past(dIn[7:4])};
  endproperty
  a_nibble_pair: assert property (p_nibble_pair)
    else $error("Two nibbles did not assemble into one byte.");

  property p_status_read;
    @(posedge clock) disable iff (!resetn)
      parRead && wide_reg && sel == lcdini_pkg::SEL_COMMAND |=>
        dataOut == {$past(busyIndicator), $past(addressCounter)} ##1 dataOe == 8'hFF;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("Status read did not return busy and address.");

  property p_early_width;
    @(posedge clock) disable iff (!resetn)
      earlyNibble && !busyIndicator |=> wide_reg && !nibblePhase_reg && busyIndicator;
  endproperty
  a_early_width: assert property (p_early_width)
    else $error("Early width command ignored in 4-bit mode.");

endmodule : lcdini_host_if

// [tb/lcdini_host_model.sv]
/*
  Host processor model: drives strobe, select, direction and data pins, parallel or serial.
  Assumes the device samples every pin through synchronisers on clock.
*/
`timescale 1ns/1ps
module lcdini_host_model (
  // Clock, serial mode pin and device outputs
  input  wire logic       clock,
  input  wire logic       serialModePin,
  input  wire logic [7:0] dataOut,
  input  wire logic [7:0] dataOe,
  // Host pins
  output logic            enablePin,
  output logic            readWritePin,
  output logic            registerSelectHigh,
  output logic            registerSelectLow,
  output logic      [7:0] dataIn
);
  logic [7:0] hostData;
  logic       hostOe;
  // A released line shows the inverse of its last value, so no stale level passes.
  assign dataIn = (dataOe & dataOut) | (~dataOe & (hostOe ? hostData : ~hostData));
  // Control pins idle low before reset ends.
  initial begin
    enablePin = 1'b0;
    readWritePin = 1'b0;
    registerSelectHigh = 1'b0;
    registerSelectLow = 1'b0;
    hostData = 8'h00;
    hostOe = 1'b0;
  end
  // One parallel strobe with select, direction and data held across both edges, or one serial frame.
  task automatic xfer(input logic [1:0] sel, input logic rw, input logic [7:0] d,
                      output logic [7:0] q);
    logic [10:0] serWord;
    serWord = {sel, rw, d};
    @(negedge clock);
    if (serialModePin) begin
      // Serial: eleven shift clocks under chip select; status shifts out from the third rise.
      registerSelectLow = 1'b0;
      for (int i = 10; i >= 0; i--) begin
        readWritePin = serWord[i];
        repeat (2) @(negedge clock);
        enablePin = 1'b1;
        repeat (6) @(negedge clock);
        if (i >= 1 && i <= 8) q[i - 1] = dataOut[0];
        enablePin = 1'b0;
        repeat (2) @(negedge clock);
      end
      registerSelectLow = 1'b1;
      repeat (8) @(negedge clock);
      return;
    end
    {registerSelectHigh, registerSelectLow} = sel;
    readWritePin = rw;
    hostData = d;
    hostOe = !rw;
    repeat (2) @(negedge clock);
    enablePin = 1'b1;
    repeat (8) @(negedge clock);
    q = dataOut;
    enablePin = 1'b0;
    repeat (8) @(negedge clock);
    hostOe = 1'b0;
  endtask : xfer
  // Status polling until idle, bounded; a narrow bus reads two halves.
  task automatic pollIdle(input logic wide, output logic [7:0] q);
    logic [7:0] lo;
    for (int i = 0; i < 50; i++) begin
      xfer(lcdini_pkg::SEL_COMMAND, 1'b1, 8'h00, q);
      if (!wide) xfer(lcdini_pkg::SEL_COMMAND, 1'b1, 8'h00, lo);
      if (!wide) q[3:0] = lo[7:4];
      if (q[7] === 1'b0) break;
    end
  endtask : pollIdle
endmodule : lcdini_host_model

// [tb/lcdini_host_if_test.sv]
/*
  Self-checking bench of the host interface: width sequence, busy refusal, narrow bus,
  lock of line count and font, status reads.
  Assumes the package, the design and the host model are compiled first.
*/
`timescale 1ns/1ps
module lcdini_host_if_test;
  // Host waits are scaled down: the device does not time them.
  localparam int BUSY = 40;
  localparam int WAIT = 60;
  logic        clock, resetn, arbitratorLineEnable, instrValid, busyIndicator;
  logic        enablePin, readWritePin, registerSelectHigh, registerSelectLow;
  logic        interfaceWide, settingsLocked, lineCount, fontSize, arbitratorSelect;
  logic        framePulse, ln, fn, serialModePin;
  logic [7:0]  dataIn, dataOut, dataOe, instrByte, q, b;
  logic [6:0]  addressCounter;
  logic [1:0]  instrSelect;
  logic [4:0]  comIndex;
  logic [31:0] seed = 32'hBF76F6E3;
  logic [7:0]  setup [3] = '{8'h0C, 8'h01, 8'h06};
  int          fails = 0, tests_run = 0, nValid = 0, n0;
  lcdini_host_if #(.BUSY_CYCLES(BUSY)) DUT (.clock(clock), .resetn(resetn),
    .serialModePin(serialModePin), .enablePin(enablePin), .readWritePin(readWritePin),
    .registerSelectHigh(registerSelectHigh), .registerSelectLow(registerSelectLow),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .addressCounter(addressCounter),
    .arbitratorLineEnable(arbitratorLineEnable), .instrValid(instrValid),
    .instrSelect(instrSelect), .instrByte(instrByte), .busyIndicator(busyIndicator),
    .interfaceWide(interfaceWide), .settingsLocked(settingsLocked), .lineCount(lineCount),
    .fontSize(fontSize), .arbitratorSelect(arbitratorSelect), .comIndex(comIndex),
    .framePulse(framePulse));
  lcdini_host_model host (.clock(clock), .serialModePin(serialModePin), .dataOut(dataOut),
    .dataOe(dataOe), .enablePin(enablePin), .readWritePin(readWritePin),
    .registerSelectHigh(registerSelectHigh), .registerSelectLow(registerSelectLow),
    .dataIn(dataIn));
  // Xorshift source, repeatable from the fixed seed.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Expected function setting byte for a line count and font.
  function automatic logic [7:0] fset(input logic l, input logic f);
    return {lcdini_pkg::FSET_TAG, 5'h00} | 8'(l) << 3 | 8'(f) << 2;
  endfunction : fset
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // Narrow-bus instruction as high half then low half, then idle poll with address check.
  task automatic put4(input logic [1:0] sel, input logic [7:0] d);
    addressCounter = 7'(xs());
    host.xfer(sel, 1'b0, d, q);
    host.xfer(sel, 1'b0, {d[3:0], 4'h0}, q);
    chk(instrByte, d);
    host.pollIdle(1'b0, q);
    chk(q, {1'b0, addressCounter});
  endtask : put4
  // Accepted instructions are counted to see refused writes.
  always @(posedge clock) if (instrValid === 1'b1) nValid++;
  // Free-running clock at 8 ns.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Hang guard.
  initial begin
    repeat (90000) @(negedge clock);
    fails++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    resetn = 1'b0;
    addressCounter = 7'h00;
    arbitratorLineEnable = 1'b0;
    serialModePin = 1'b0;
    repeat (20) @(negedge clock);
    resetn = 1'b1;
    chk({interfaceWide, settingsLocked, lineCount, fontSize}, 8'h08);
    repeat (WAIT) @(negedge clock);
    for (int i = 0; i < 3; i++) begin
      addressCounter = 7'(xs());
      arbitratorLineEnable = 1'(xs());
      host.xfer(lcdini_pkg::SEL_COMMAND, 1'b0, {lcdini_pkg::WIDTH8_NIBBLE, 4'(xs())}, q);
      chk({instrSelect, instrByte[7:4]}, {2'h0, lcdini_pkg::SEL_COMMAND, 4'h3});
      repeat (WAIT / (i + 1)) @(negedge clock);
      host.pollIdle(1'b1, q);
      chk(q, {1'b0, addressCounter});
    end
    chk({interfaceWide, settingsLocked}, 8'h02);
    n0 = nValid;
    host.xfer(lcdini_pkg::SEL_COMMAND, 1'b0, 8'h20, q);
    host.xfer(lcdini_pkg::SEL_COMMAND, 1'b0, fset(1'b1, 1'b1), q);
    chk(8'(nValid - n0), 8'h01);
    chk({interfaceWide, settingsLocked}, 8'h00);
    host.pollIdle(1'b0, q);
    chk(q[7], 1'b0);
    host.xfer(lcdini_pkg::SEL_COMMAND, 1'b0, 8'h30, q);
    chk(interfaceWide, 8'h01);
    host.pollIdle(1'b1, q);
    chk(q[7], 1'b0);
    host.xfer(lcdini_pkg::SEL_COMMAND, 1'b0, 8'h20, q);
    host.pollIdle(1'b0, q);
    chk(q[7], 1'b0);
    repeat (WAIT) @(negedge clock);
    ln = 1'(xs());
    fn = 1'(xs());
    put4(lcdini_pkg::SEL_COMMAND, fset(ln, fn));
    chk({settingsLocked, lineCount, fontSize}, {5'h00, 1'b1, ln, fn});
    put4(lcdini_pkg::SEL_COMMAND, fset(!ln, !fn));
    chk({interfaceWide, lineCount, fontSize}, {6'h00, ln, fn});
    foreach (setup[i]) put4(lcdini_pkg::SEL_COMMAND, setup[i]);
    b = 8'(1'(xs()));
    put4(lcdini_pkg::SEL_EXPANSION, {lcdini_pkg::ARB_LINE_CODE, b[0]});
    chk(arbitratorSelect, b);
    // Serial mode after a fresh reset: busy poll, then the final setting straight away.
    resetn = 1'b0;
    serialModePin = 1'b1;
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    chk({interfaceWide, settingsLocked, lineCount, fontSize}, 8'h08);
    repeat (WAIT) @(negedge clock);
    host.pollIdle(1'b1, q);
    chk(q, {1'b0, addressCounter});
    host.xfer(lcdini_pkg::SEL_COMMAND, 1'b0, fset(1'b1, fn), q);
    chk(instrByte, fset(1'b1, fn));
    chk({settingsLocked, lineCount, fontSize, interfaceWide}, {4'h0, 2'h3, fn, 1'b1});
    host.pollIdle(1'b1, q);
    chk(q, {1'b0, addressCounter});
    wrap_up();
  end
endmodule : lcdini_host_if_test
